// *** src/prft_params.svh ***
// Register offsets, field positions, reset values, FIFO depth and interrupt bits of the transfer engine.
`ifndef PRFT_PARAMS_SVH
`define PRFT_PARAMS_SVH
`define PRFT_OFS_FETCH_ADDR_LEN 12'h308
`define PRFT_OFS_FETCH_CMD      12'h30C
`define PRFT_OFS_STORE_ADDR_LEN 12'h310
`define PRFT_OFS_STORE_CMD      12'h314
`define PRFT_OFS_FETCH_DATA     12'h318
`define PRFT_OFS_STORE_DATA     12'h31C
`define PRFT_OFS_IRQ_STATUS     12'h320
`define PRFT_OFS_IRQ_MASK       12'h324
`define PRFT_BIT_ACTIVE         31
`define PRFT_BIT_CANCEL         30
`define PRFT_CNT_MSB            12
`define PRFT_CNT_LSB            8
`define PRFT_BIT_AVAIL          0
`define PRFT_LEN_MSB            31
`define PRFT_LEN_LSB            16
`define PRFT_ADR_MSB            15
`define PRFT_ADR_LSB            0
`define PRFT_RST_LEN            16'h0000
`define PRFT_RST_ADR            16'h0000
`define PRFT_FIFO_DEPTH         16
`define PRFT_IRQ_FETCH_DONE     0
`define PRFT_IRQ_STORE_DONE     1
`define PRFT_IRQ_BITS           2
`endif

// *** src/prft_pkg.sv ***
// Types shared by the process RAM transfer engine.
package prft_pkg;
    typedef enum logic [1:0] {
        PRFT_IDLE  = 2'b00,
        PRFT_READ  = 2'b01,
        PRFT_WRITE = 2'b10
    } prft_ram_e;
endpackage

// *** src/prft_engine.sv ***
// Process RAM to FIFO transfer engine with AXI4-Lite register slave.
// What this block does
// - Fetch-active write of one starts RAM reading.
// - Fetch-active stays set until all bytes read.
// - Writing zero to start or cancel: no effect.
// - Fetch-cancel stops read, clears active, self-clears.
// - Read cancel empties FIFO, flag and count.
// - Fetch count resets zero, rises on fill.
// - Fetch count drops per whole host DWORD read.
// - Fetch-ready flag set while FIFO holds data.
// - Store length counts down as data leaves.
// - Store address counts up as data written.
// - Fetch length decrements, fetch address increments.
// - Store-active starts write, self-clears when done.
// - Store space resets 16, tracks FIFO use.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "prft_params.svh"
module prft_engine #(
    parameter int DEPTH = `PRFT_FIFO_DEPTH
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clk_en,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [15:0]      ram_addr,
    output logic             ram_rd,
    output logic             ram_wr,
    output logic [31:0]      ram_wdata,
    output logic [3:0]       ram_be,
    input  wire logic [31:0] ram_rdata,
    output logic             irq
);
    localparam int CW = $clog2(DEPTH + 1);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || DEPTH > 31 || (DEPTH & (DEPTH - 1)) != 0) begin
            $error("DEPTH must be a power of two from 2 to 16.");
        end
    end

    // Bytes moved by one RAM word access, limited by alignment and what remains.
    function automatic logic [2:0] chunk(input logic [15:0] adr, input logic [15:0] len);
        logic [2:0] room;
        room = 3'(3'd4 - {1'b0, adr[1:0]});
        chunk = (len < {13'h0, room}) ? len[2:0] : room;
    endfunction

    // Byte-lane enables for a chunk starting at the given address.
    function automatic logic [3:0] lanes(input logic [1:0] off, input logic [2:0] n);
        lanes = 4'(((5'h01 << n) - 5'h01) << off);
    endfunction

    // Register state.
    logic [31:0] f_al_r, f_al_nxt, s_al_r, s_al_nxt;
    logic        f_act_r, f_act_nxt, s_act_r, s_act_nxt;
    logic [31:0] ffq_r [DEPTH], ffq_nxt [DEPTH];
    logic [31:0] sfq_r [DEPTH], sfq_nxt [DEPTH];
    logic [AW-1:0] fwp_r, fwp_nxt, frp_r, frp_nxt, swp_r, swp_nxt, srp_r, srp_nxt;
    logic [CW-1:0] fcnt_r, fcnt_nxt, scnt_r, scnt_nxt;
    logic [31:0] fasm_r, fasm_nxt;
    logic [1:0]  fbyte_r, fbyte_nxt;
    logic [1:0]  sbyte_r, sbyte_nxt;
    logic [`PRFT_IRQ_BITS-1:0] ist_r, ist_nxt, imask_r, imask_nxt;
    prft_pkg::prft_ram_e ram_st_r, ram_st_nxt;
    logic [15:0] ram_addr_nxt;
    logic [31:0] ram_wdata_nxt;
    logic [3:0]  ram_be_nxt;
    logic [2:0]  ram_n_r, ram_n_nxt;
    logic        awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
    logic [1:0]  bresp_nxt, rresp_nxt;
    logic [31:0] rdata_nxt;
    logic        irq_nxt;
    logic [11:0] aw_r, aw_nxt;
    logic        awh_r, awh_nxt;
    logic [31:0] wd_r, wd_nxt;
    logic [3:0]  ws_r, ws_nxt;
    logic        wh_r, wh_nxt;

    always_comb begin
        logic        wr_go, rd_go, hit;
        logic [31:0] rd;
        logic [31:0] word;
        logic [2:0]  n;
        f_al_nxt = f_al_r;
        s_al_nxt = s_al_r;
        f_act_nxt = f_act_r;
        s_act_nxt = s_act_r;
        ffq_nxt = ffq_r;
        sfq_nxt = sfq_r;
        fwp_nxt = fwp_r;
        frp_nxt = frp_r;
        swp_nxt = swp_r;
        srp_nxt = srp_r;
        fcnt_nxt = fcnt_r;
        scnt_nxt = scnt_r;
        fasm_nxt = fasm_r;
        fbyte_nxt = fbyte_r;
        sbyte_nxt = sbyte_r;
        ist_nxt = ist_r;
        imask_nxt = imask_r;
        ram_st_nxt = prft_pkg::PRFT_IDLE;
        ram_addr_nxt = ram_addr;
        ram_wdata_nxt = ram_wdata;
        ram_be_nxt = 4'h0;
        ram_n_nxt = ram_n_r;
        aw_nxt = aw_r;
        awh_nxt = awh_r;
        wd_nxt = wd_r;
        ws_nxt = ws_r;
        wh_nxt = wh_r;
        bvalid_nxt = s_axi_bvalid && !s_axi_bready;
        bresp_nxt = s_axi_bresp;
        rvalid_nxt = s_axi_rvalid && !s_axi_rready;
        rresp_nxt = s_axi_rresp;
        rdata_nxt = s_axi_rdata;
        wr_go = 1'b0;
        rd_go = 1'b0;
        hit = 1'b0;
        rd = 32'h0;
        word = 32'h0;
        n = 3'h0;

        // Capture write address and data in either order.
        if (s_axi_awvalid && s_axi_awready) begin
            aw_nxt = s_axi_awaddr;
            awh_nxt = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wd_nxt = s_axi_wdata;
            ws_nxt = s_axi_wstrb;
            wh_nxt = 1'b1;
        end
        wr_go = awh_r && wh_r && !s_axi_bvalid;
        rd_go = s_axi_arvalid && s_axi_arready;

        // The RAM port completes the access issued in the previous cycle.
        if (ram_st_r == prft_pkg::PRFT_READ && f_act_r) begin
            word = ram_rdata >> {ram_addr[1:0], 3'b000};
            for (int i = 0; i < 4; i++) begin
                if (3'(i) < ram_n_r) begin
                    fasm_nxt[8*fbyte_nxt +: 8] = word[8*i +: 8];
                    fbyte_nxt = fbyte_nxt + 2'd1;
                    if (fbyte_nxt == 2'd0 || 16'(3'(i) + 3'd1) == f_al_r[31:16]) begin
                        ffq_nxt[fwp_nxt] = fasm_nxt;
                        fwp_nxt = fwp_nxt + AW'(1);
                        fcnt_nxt = fcnt_nxt + CW'(1);
                        fasm_nxt = 32'h0;
                        fbyte_nxt = 2'd0;
                    end
                end
            end
            f_al_nxt[15:0] = f_al_r[15:0] + {13'h0, ram_n_r};
            f_al_nxt[31:16] = f_al_r[31:16] - {13'h0, ram_n_r};
            if (f_al_nxt[31:16] == 16'h0) begin
                f_act_nxt = 1'b0;
                ist_nxt[`PRFT_IRQ_FETCH_DONE] = 1'b1;
            end
        end
        if (ram_st_r == prft_pkg::PRFT_WRITE && s_act_r) begin
            s_al_nxt[15:0] = s_al_r[15:0] + {13'h0, ram_n_r};
            s_al_nxt[31:16] = s_al_r[31:16] - {13'h0, ram_n_r};
            if (sbyte_r + ram_n_r[1:0] == 2'd0 || s_al_nxt[31:16] == 16'h0) begin
                srp_nxt = srp_r + AW'(1);
                scnt_nxt = scnt_nxt + CW'(1);
                sbyte_nxt = 2'd0;
            end else begin
                sbyte_nxt = sbyte_r + ram_n_r[1:0];
            end
            if (s_al_nxt[31:16] == 16'h0) begin
                s_act_nxt = 1'b0;
                ist_nxt[`PRFT_IRQ_STORE_DONE] = 1'b1;
            end
        end

        // Issue the next RAM access; a read waits for a free FIFO entry.
        if (ram_st_r == prft_pkg::PRFT_IDLE) begin
            if (f_act_r && fcnt_r < CW'(DEPTH)) begin
                n = chunk(f_al_r[15:0], f_al_r[31:16]);
                ram_st_nxt = prft_pkg::PRFT_READ;
                ram_addr_nxt = f_al_r[15:0];
                ram_n_nxt = n;
            end else if (s_act_r && scnt_r < CW'(DEPTH)) begin
                n = chunk(s_al_r[15:0], s_al_r[31:16]);
                if ({1'b0, sbyte_r} + n > 3'd4) begin
                    n = 3'(3'd4 - {1'b0, sbyte_r});
                end
                ram_st_nxt = prft_pkg::PRFT_WRITE;
                ram_addr_nxt = s_al_r[15:0];
                ram_n_nxt = n;
                ram_be_nxt = lanes(s_al_r[1:0], n);
                ram_wdata_nxt = (sfq_r[srp_r] >> {sbyte_r, 3'b000}) << {s_al_r[1:0], 3'b000};
            end
        end

        // Register reads; a fetch data read pops one whole DWORD.
        if (rd_go) begin
            hit = 1'b1;
            unique case (s_axi_araddr)
                `PRFT_OFS_FETCH_ADDR_LEN: rd = f_al_r;
                `PRFT_OFS_STORE_ADDR_LEN: rd = s_al_r;
                `PRFT_OFS_FETCH_CMD: begin
                    rd[`PRFT_BIT_ACTIVE] = f_act_r;
                    rd[`PRFT_CNT_MSB:`PRFT_CNT_LSB] = 5'(fcnt_r);
                    rd[`PRFT_BIT_AVAIL] = fcnt_r != CW'(0);
                end
                `PRFT_OFS_STORE_CMD: begin
                    rd[`PRFT_BIT_ACTIVE] = s_act_r;
                    rd[`PRFT_CNT_MSB:`PRFT_CNT_LSB] = 5'(scnt_r);
                    rd[`PRFT_BIT_AVAIL] = scnt_r != CW'(0);
                end
                `PRFT_OFS_FETCH_DATA: begin
                    rd = ffq_r[frp_r];
                    if (fcnt_r != CW'(0)) begin
                        frp_nxt = frp_r + AW'(1);
                        fcnt_nxt = fcnt_nxt - CW'(1);
                    end
                end
                `PRFT_OFS_IRQ_STATUS: rd = 32'(ist_r);
                `PRFT_OFS_IRQ_MASK: rd = 32'(imask_r);
                default: hit = 1'b0;
            endcase
            rdata_nxt = rd;
            rresp_nxt = hit ? 2'b00 : 2'b10;
            rvalid_nxt = 1'b1;
        end

        // Register writes.
        if (wr_go) begin
            hit = 1'b1;
            awh_nxt = 1'b0;
            wh_nxt = 1'b0;
            unique case (aw_r)
                `PRFT_OFS_FETCH_ADDR_LEN: f_al_nxt = wd_r;
                `PRFT_OFS_STORE_ADDR_LEN: s_al_nxt = wd_r;
                `PRFT_OFS_FETCH_CMD: begin
                    if (wd_r[`PRFT_BIT_CANCEL]) begin
                        // Cancel beats start written in the same word.
                        f_act_nxt = 1'b0;
                        fcnt_nxt = CW'(0);
                        fwp_nxt = AW'(0);
                        frp_nxt = AW'(0);
                        fbyte_nxt = 2'd0;
                        fasm_nxt = 32'h0;
                    end else if (wd_r[`PRFT_BIT_ACTIVE] && f_al_r[31:16] != 16'h0) begin
                        f_act_nxt = 1'b1;
                    end
                end
                `PRFT_OFS_STORE_CMD: begin
                    if (wd_r[`PRFT_BIT_CANCEL]) begin
                        s_act_nxt = 1'b0;
                        scnt_nxt = CW'(DEPTH);
                        swp_nxt = AW'(0);
                        srp_nxt = AW'(0);
                        sbyte_nxt = 2'd0;
                    end else if (wd_r[`PRFT_BIT_ACTIVE] && s_al_r[31:16] != 16'h0) begin
                        s_act_nxt = 1'b1;
                    end
                end
                `PRFT_OFS_STORE_DATA: begin
                    // Only a full DWORD write consumes space; partial writes are ignored.
                    if (ws_r == 4'hF && scnt_r != CW'(0)) begin
                        sfq_nxt[swp_r] = wd_r;
                        swp_nxt = swp_r + AW'(1);
                        scnt_nxt = scnt_nxt - CW'(1);
                    end
                end
                `PRFT_OFS_IRQ_STATUS: ist_nxt = ist_nxt & ~(wd_r[`PRFT_IRQ_BITS-1:0] & ist_r);
                `PRFT_OFS_IRQ_MASK: imask_nxt = wd_r[`PRFT_IRQ_BITS-1:0];
                default: hit = 1'b0;
            endcase
            // A done event in this cycle survives a simultaneous clear.
            if (ram_st_r == prft_pkg::PRFT_READ && f_act_r && f_al_nxt[31:16] == 16'h0
                && f_act_r && !(aw_r == `PRFT_OFS_FETCH_CMD && wd_r[`PRFT_BIT_CANCEL])) begin
                ist_nxt[`PRFT_IRQ_FETCH_DONE] = 1'b1;
            end
            if (ram_st_r == prft_pkg::PRFT_WRITE && s_act_r && s_al_nxt[31:16] == 16'h0) begin
                ist_nxt[`PRFT_IRQ_STORE_DONE] = 1'b1;
            end
            bresp_nxt = hit ? 2'b00 : 2'b10;
            bvalid_nxt = 1'b1;
        end
        // Ready stays low for as long as a write response is pending, the rising edge included.
        awready_nxt = !awh_nxt && !bvalid_nxt;
        wready_nxt = !wh_nxt && !bvalid_nxt;
        arready_nxt = !rvalid_nxt && !rd_go;
        irq_nxt = |(ist_nxt & imask_nxt);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            f_al_r <= {`PRFT_RST_LEN, `PRFT_RST_ADR};
            s_al_r <= {`PRFT_RST_LEN, `PRFT_RST_ADR};
            f_act_r <= 1'b0;
            s_act_r <= 1'b0;
            for (int i = 0; i < DEPTH; i++) begin
                ffq_r[i] <= 32'h0;
                sfq_r[i] <= 32'h0;
            end
            fwp_r <= '0;
            frp_r <= '0;
            swp_r <= '0;
            srp_r <= '0;
            fcnt_r <= '0;
            scnt_r <= CW'(DEPTH);
            fasm_r <= 32'h0;
            fbyte_r <= 2'd0;
            sbyte_r <= 2'd0;
            ist_r <= '0;
            imask_r <= '0;
            ram_st_r <= prft_pkg::PRFT_IDLE;
            ram_addr <= 16'h0;
            ram_wdata <= 32'h0;
            ram_be <= 4'h0;
            ram_n_r <= 3'h0;
            ram_rd <= 1'b0;
            ram_wr <= 1'b0;
            aw_r <= 12'h0;
            awh_r <= 1'b0;
            wd_r <= 32'h0;
            ws_r <= 4'h0;
            wh_r <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'b00;
            s_axi_rdata <= 32'h0;
            irq <= 1'b0;
        end else if (clk_en) begin
            f_al_r <= f_al_nxt;
            s_al_r <= s_al_nxt;
            f_act_r <= f_act_nxt;
            s_act_r <= s_act_nxt;
            ffq_r <= ffq_nxt;
            sfq_r <= sfq_nxt;
            fwp_r <= fwp_nxt;
            frp_r <= frp_nxt;
            swp_r <= swp_nxt;
            srp_r <= srp_nxt;
            fcnt_r <= fcnt_nxt;
            scnt_r <= scnt_nxt;
            fasm_r <= fasm_nxt;
            fbyte_r <= fbyte_nxt;
            sbyte_r <= sbyte_nxt;
            ist_r <= ist_nxt;
            imask_r <= imask_nxt;
            ram_st_r <= ram_st_nxt;
            ram_addr <= ram_addr_nxt;
            ram_wdata <= ram_wdata_nxt;
            ram_be <= ram_be_nxt;
            ram_n_r <= ram_n_nxt;
            ram_rd <= (ram_st_nxt == prft_pkg::PRFT_READ);
            ram_wr <= (ram_st_nxt == prft_pkg::PRFT_WRITE);
            aw_r <= aw_nxt;
            awh_r <= awh_nxt;
            wd_r <= wd_nxt;
            ws_r <= ws_nxt;
            wh_r <= wh_nxt;
            s_axi_awready <= awready_nxt;
            s_axi_wready <= wready_nxt;
            s_axi_bvalid <= bvalid_nxt;
            s_axi_bresp <= bresp_nxt;
            s_axi_arready <= arready_nxt;
            s_axi_rvalid <= rvalid_nxt;
            s_axi_rresp <= rresp_nxt;
            s_axi_rdata <= rdata_nxt;
            irq <= irq_nxt;
        end
    end
endmodule

// *** verification/prft_engine_asserts.sv ***
// Port-level checks for the process RAM transfer engine.
`timescale 1ns/1ns
module prft_engine_asserts #(
    parameter int DEPTH = 16
) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        clk_en,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic [11:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic [15:0] ram_addr,
    input wire logic        ram_rd,
    input wire logic        ram_wr
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !clk_en);
    logic ar_bad;
    assign ar_bad = s_axi_araddr < 12'h308 || s_axi_araddr > 12'h324 || s_axi_araddr[1:0] != 2'h0;
    property p_rd_spacing;
        ram_rd |=> !ram_rd;
    endproperty
    a_rd_spacing: assert property (p_rd_spacing) else $error("RAM reads too close");
    property p_rw_excl;
        !(ram_rd && ram_wr);
    endproperty
    a_rw_excl: assert property (p_rw_excl) else $error("RAM read and write together");
    property p_rd_range;
        ram_rd |-> ram_addr >= 16'h1000 && ram_addr <= 16'h2FFF;
    endproperty
    a_rd_range: assert property (p_rd_range) else $error("RAM read outside range");
    property p_wr_range;
        ram_wr |-> ram_addr >= 16'h1000 && ram_addr <= 16'h2FFF;
    endproperty
    a_wr_range: assert property (p_wr_range) else $error("RAM write outside range");
    property p_b_soon;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_b_soon: assert property (p_b_soon) else $error("Write response late");
    property p_b_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_b_block: assert property (p_b_block) else $error("Write taken during response");
    property p_r_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rresp == {$past(ar_bad), 1'b0};
    endproperty
    a_r_answer: assert property (p_r_answer) else $error("Read response wrong");
    property p_r_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_r_block: assert property (p_r_block) else $error("Read taken during response");
endmodule
bind prft_engine prft_engine_asserts #(.DEPTH(DEPTH)) u_prft_engine_asserts (
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .ram_addr(ram_addr), .ram_rd(ram_rd), .ram_wr(ram_wr)
);

// *** verification/prft_ram_model.sv ***
// Behavioural process RAM that answers the engine's read and write strobes.
`timescale 1ns/1ns
module prft_ram_model (
    input  wire logic        aclk,
    input  wire logic [15:0] ram_addr,
    input  wire logic        ram_rd,
    input  wire logic        ram_wr,
    input  wire logic [31:0] ram_wdata,
    input  wire logic [3:0]  ram_be,
    output logic      [31:0] ram_rdata
);
    logic [31:0] mem [0:2047];
    logic [15:0] ofs;
    logic [10:0] last_idx;
    logic        rd_d = 1'b0;
    logic [31:0] junk = 32'h5A5A_0F0F;
    assign ofs = ram_addr - 16'h1000;
    // Except during a read and the cycle after it, the data lines churn, so a mistimed sample cannot match by luck.
    assign ram_rdata = ram_rd ? mem[ofs[12:2]] : rd_d ? mem[last_idx] : junk;
    always @(posedge aclk) begin
        junk     <= {junk[30:0], ~junk[31]};
        rd_d     <= ram_rd;
        last_idx <= ofs[12:2];
        for (int b = 0; b < 4; b++) begin
            if (ram_wr && ram_be[b]) mem[ofs[12:2]][8*b +: 8] <= ram_wdata[8*b +: 8];
        end
    end
endmodule

// *** verification/prft_engine_tb_top.sv ***
// Self-checking bench for the process RAM transfer engine.
`timescale 1ns/1ns
`include "prft_params.svh"
module prft_engine_tb_top;
    localparam logic [11:0] fal = `PRFT_OFS_FETCH_ADDR_LEN;
    localparam logic [11:0] fcmd = `PRFT_OFS_FETCH_CMD;
    localparam logic [11:0] sal = `PRFT_OFS_STORE_ADDR_LEN;
    localparam logic [11:0] scmd = `PRFT_OFS_STORE_CMD;
    localparam logic [11:0] fdat = `PRFT_OFS_FETCH_DATA;
    localparam logic [11:0] sdat = `PRFT_OFS_STORE_DATA;
    localparam logic [11:0] ists = `PRFT_OFS_IRQ_STATUS;
    localparam logic [11:0] imsk = `PRFT_OFS_IRQ_MASK;
    logic        aclk;
    logic        aresetn = 1'b0;
    logic        clk_en = 1'b1;
    logic [11:0] awaddr = 12'h000;
    logic        awvalid = 1'b0;
    logic        awready;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'hF;
    logic        wvalid = 1'b0;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready = 1'b0;
    logic [11:0] araddr = 12'h000;
    logic        arvalid = 1'b0;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready = 1'b0;
    logic [15:0] ram_addr;
    logic        ram_rd;
    logic        ram_wr;
    logic [31:0] ram_wdata;
    logic [3:0]  ram_be;
    logic [31:0] ram_rdata;
    logic        irq;
    int          miscompares = 0;
    int          comparisons = 0;
    int          cycles = 0;
    logic [31:0] seed = 32'hE472;
    logic [31:0] img [0:2047];
    logic [31:0] got;
    logic [1:0]  resp;
    prft_engine #(.DEPTH(16)) u_prft_engine (
        .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ram_addr(ram_addr), .ram_rd(ram_rd), .ram_wr(ram_wr), .ram_wdata(ram_wdata),
        .ram_be(ram_be), .ram_rdata(ram_rdata), .irq(irq)
    );
    prft_ram_model u_ram (
        .aclk(aclk), .ram_addr(ram_addr), .ram_rd(ram_rd), .ram_wr(ram_wr),
        .ram_wdata(ram_wdata), .ram_be(ram_be), .ram_rdata(ram_rdata)
    );
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h8020_0003 : 32'h0);
    endfunction
    function automatic logic [31:0] cmdw(input logic act, input logic [4:0] cnt);
        return {act, 18'h0_0000, cnt, 7'h00, |cnt};
    endfunction
    function automatic int wi(input logic [15:0] x);
        return int'((x - 16'h1000) >> 2);
    endfunction
    task automatic conclude();
        if (miscompares == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        rd(a, got);
        check(got, e);
    endtask
    task automatic wait_idle(input logic [11:0] a);
        do rd(a, got); while (got[31]);
    endtask
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end
    initial begin
        logic [15:0] a;
        for (int i = 0; i < 2048; i++) begin
            seed = lfsr(seed);
            img[i] = seed;
            u_ram.mem[i] = seed;
        end
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rdchk(fcmd, 32'h0);
        rdchk(scmd, cmdw(1'b0, 5'h10));
        rdchk(sal, 32'h0);
        rd(12'h400, got);
        check({30'h0, resp}, 32'h2);
        wr(12'h400, 32'h0);
        check({30'h0, resp}, 32'h2);
        seed = lfsr(seed);
        a = 16'h1000 + 16'(seed % 1984) * 16'h0004;
        wr(fal, {16'h0050, a});
        wr(fcmd, 32'h8000_0000);
        // With the enable low the RAM address must hold while a fetch is under way.
        clk_en <= 1'b0;
        @(posedge aclk);
        got = 32'(ram_addr);
        repeat (20) @(posedge aclk);
        check(32'(ram_addr), got);
        clk_en <= 1'b1;
        do rd(fcmd, got); while (got[12:8] != 5'h10);
        rdchk(fcmd, cmdw(1'b1, 5'h10));
        rdchk(fal, {16'h0010, a + 16'h0040});
        for (int i = 0; i < 10; i++) rdchk(fdat, img[wi(a) + i]);
        wait_idle(fcmd);
        for (int i = 10; i < 20; i++) begin
            rdchk(fcmd, cmdw(1'b0, 5'(20 - i)));
            rdchk(fdat, img[wi(a) + i]);
        end
        rdchk(fcmd, 32'h0);
        rdchk(fal, {16'h0000, a + 16'h0050});
        rdchk(ists, 32'h1);
        check({31'h0, irq}, 32'h0);
        wr(imsk, 32'h1);
        check({30'h0, resp}, 32'h0);
        repeat (2) @(posedge aclk);
        check({31'h0, irq}, 32'h1);
        wr(ists, 32'h1);
        repeat (2) @(posedge aclk);
        check({31'h0, irq}, 32'h0);
        wr(fal, {16'h0080, a});
        wr(fcmd, 32'h8000_0000);
        do rd(fcmd, got); while (got[12:8] != 5'h10);
        wr(fcmd, 32'h0);
        rdchk(fcmd, cmdw(1'b1, 5'h10));
        wr(fcmd, 32'h4000_0000);
        rdchk(fcmd, 32'h0);
        wr(fcmd, 32'h4000_0000);
        rdchk(fcmd, 32'h0);
        seed = lfsr(seed);
        a = 16'h1000 + 16'(seed % 1984) * 16'h0004;
        wr(sal, {16'h0020, a});
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            img[wi(a) + i] = seed;
            wr(sdat, seed);
        end
        wstrb <= 4'h3;
        wr(sdat, 32'hFFFF_FFFF);
        wstrb <= 4'hF;
        rdchk(scmd, cmdw(1'b0, 5'h08));
        wr(scmd, 32'h8000_0000);
        wait_idle(scmd);
        rdchk(scmd, cmdw(1'b0, 5'h10));
        rdchk(sal, {16'h0000, a + 16'h0020});
        wr(fal, {16'h0020, a});
        wr(fcmd, 32'h8000_0000);
        wait_idle(fcmd);
        for (int i = 0; i < 8; i++) rdchk(fdat, img[wi(a) + i]);
        conclude();
    end
endmodule
